// file: adc_port_pkg.sv
package adc_port_pkg;

    // ==========================================================
    // widths and counts
    localparam int RES_W        = 18;
    localparam int BIT_W        = 5;
    localparam logic [BIT_W-1:0] BIT_LAST = 5'h11;
    localparam int CORE_CLK_MHZ = 250;
    // conversion time is not fixed by the pins; plain default
    localparam int CONV_TIME_NS = 1000;
    localparam int CONV_CYCLES  = (CONV_TIME_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 9;
    // one quarter of the internal serial clock period
    localparam int PHASE_CYCLES = 2;
    localparam int PH_W         = 2;
    localparam logic [PH_W-1:0] PHASE_RELOAD = PH_W'(PHASE_CYCLES - 1);
    localparam logic [1:0] MODE_SERIAL = 2'h3;
    localparam logic [1:0] FIFO_FULL   = 2'h2;

    // ==========================================================
    // types
    typedef logic [RES_W-1:0] word_t;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_RUN  = 2'b01,
        CV_PUSH = 2'b10
    } conv_state_e;

    typedef enum logic [0:0] {
        RD_IDLE  = 1'b0,
        RD_SHIFT = 1'b1
    } rd_state_e;

    typedef enum logic [1:0] {
        LK_IDLE  = 2'b00,
        LK_SHIFT = 2'b01,
        LK_DONE  = 2'b10
    } link_state_e;

    typedef struct packed {
        logic [1:0] mode;
        logic       clk_ext;
        logic       fmt_2c;
        logic       mk_pol;
        logic       rdc;
        logic       cs_n;
        logic       rd_n;
        logic       cnv_n;
        logic       dev_rst;
    } pins_s;

    localparam pins_s PINS_RST = '{mode: 2'h0, clk_ext: 1'b0, fmt_2c: 1'b0, mk_pol: 1'b0,
                                   rdc: 1'b0, cs_n: 1'b1, rd_n: 1'b1, cnv_n: 1'b1,
                                   dev_rst: 1'b0};

endpackage : adc_port_pkg

// file: adc_result_output_port.sv
`timescale 1ns/1ps

// Notes on behaviour
// - non-serial modes drive pins 10..13 as result bits
// - result bits 14..17 driven in every mode
// - serial result shifted out msb first
// - format pin picks binary or twos complement
// - internal clock: data stable across both edges
// - external clock edge choice follows invert pin
// - clock pin output internal, input external
// - frame marker spans read, polarity selectable
// - unfinished external read at completion flags error
// - busy high from start until result latched
// - outputs enabled only with select and read low, except serial pins 11..13
// - chip select gates the external clock
// - reset pin aborts conversion and clears logic
// - conversion start falling edge begins conversion
// - read-timing pin allows reading during conversion
// - result is an eighteen bit word
module adc_result_output_port #(
    parameter int RES_W       = adc_port_pkg::RES_W,
    parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_link_sclk,
    input  wire logic             i_device_reset,
    input  wire logic             i_conversion_start_n,
    input  wire logic             i_cs_n,
    input  wire logic             i_rd_n,
    input  wire logic [1:0]       i_mode,
    input  wire logic             i_clock_source_select,
    input  wire logic             i_number_format_select,
    input  wire logic             i_frame_marker_polarity,
    input  wire logic             i_shift_clock_invert,
    input  wire logic             i_read_timing_or_chain_in,
    input  wire logic [RES_W-1:0] i_conv_result,
    output logic      [RES_W-1:0] o_data,
    output logic      [RES_W-1:0] o_data_oe,
    output logic                  o_busy,
    output logic                  o_ext_serial_result_out
);

    generate
        if (RES_W != adc_port_pkg::RES_W) begin : g_bad_width
            $error("result width must match the package word");
        end
        if (CONV_CYCLES < 1 || CONV_CYCLES >= (1 << adc_port_pkg::CNT_W)) begin : g_bad_conv
            $error("conversion cycle count out of counter range");
        end
    endgenerate

    // ==========================================================
    // core state
    typedef struct packed {
        adc_port_pkg::pins_s         s1;
        adc_port_pkg::pins_s         s2;
        logic                        cnv_d;
        adc_port_pkg::conv_state_e   cst;
        logic [adc_port_pkg::CNT_W-1:0] ccnt;
        logic                        busy;
        logic [1:0][RES_W-1:0]       fq;
        logic                        wp;
        logic                        rp;
        logic [1:0]                  cnt;
        adc_port_pkg::word_t         outreg;
        logic                        fresh;
        logic                        ra1;
        logic                        ra2;
        adc_port_pkg::rd_state_e     rdst;
        adc_port_pkg::word_t         sh;
        logic [adc_port_pkg::BIT_W-1:0] bcnt;
        logic [1:0]                  ph;
        logic [adc_port_pkg::PH_W-1:0] pcnt;
        logic                        sclk;
        logic                        sdo;
        logic                        mark;
        logic                        rderr;
        adc_port_pkg::word_t         data;
        adc_port_pkg::word_t         oe;
    } core_s;

    typedef struct packed {
        logic                        r1;
        logic                        r2;
        logic                        c1;
        logic                        c2;
        adc_port_pkg::link_state_e   lk;
        logic                        act;
        adc_port_pkg::word_t         sh;
        logic [adc_port_pkg::BIT_W-1:0] bcnt;
        logic                        sdo;
    } link_s;

    core_s st_r;
    core_s st_nxt;
    link_s ls_r;
    link_s ls_nxt;
    logic  fall;
    logic  push;
    logic  pop;
    logic  start;
    logic  serial;
    logic  ext;
    logic  en;
    logic  reading;
    logic  link_clk;

    // ==========================================================
    // core domain
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = '{mode: i_mode, clk_ext: i_clock_source_select,
                      fmt_2c: i_number_format_select, mk_pol: i_frame_marker_polarity,
                      rdc: i_read_timing_or_chain_in, cs_n: i_cs_n, rd_n: i_rd_n,
                      cnv_n: i_conversion_start_n, dev_rst: i_device_reset};
        st_nxt.s2 = st_r.s1;
        st_nxt.cnv_d = st_r.s2.cnv_n;
        st_nxt.ra1 = ls_r.act;
        st_nxt.ra2 = st_r.ra1;
        st_nxt.rderr = 1'b0;
        serial = (st_r.s2.mode == adc_port_pkg::MODE_SERIAL);
        ext = st_r.s2.clk_ext;
        en = !st_r.s2.cs_n && !st_r.s2.rd_n;
        fall = st_r.cnv_d && !st_r.s2.cnv_n;
        push = 1'b0;
        start = 1'b0;

        case (st_r.cst)
            adc_port_pkg::CV_IDLE: begin
                if (fall) begin
                    st_nxt.cst = adc_port_pkg::CV_RUN;
                    st_nxt.ccnt = adc_port_pkg::CNT_W'(CONV_CYCLES - 1);
                    st_nxt.busy = 1'b1;
                end
            end
            adc_port_pkg::CV_RUN: begin
                if (st_r.ccnt == '0) begin
                    st_nxt.cst = adc_port_pkg::CV_PUSH;
                end else begin
                    st_nxt.ccnt = st_r.ccnt - 1'b1;
                end
            end
            adc_port_pkg::CV_PUSH: begin
                // a full buffer holds busy high rather than drop a result
                if (st_r.cnt != adc_port_pkg::FIFO_FULL) begin
                    push = 1'b1;
                    st_nxt.cst = adc_port_pkg::CV_IDLE;
                    st_nxt.busy = 1'b0;
                end
            end
            default: begin
                st_nxt.cst = adc_port_pkg::CV_IDLE;
            end
        endcase

        if (push) begin
            st_nxt.fq[st_r.wp] = i_conv_result ^ {st_r.s2.fmt_2c, {(RES_W-1){1'b0}}};
            st_nxt.wp = ~st_r.wp;
            if (serial && ext && st_r.ra2 && en) begin
                st_nxt.rderr = 1'b1;
            end
        end

        // internal-clock read start
        if (st_r.rdst == adc_port_pkg::RD_IDLE && serial && !ext && en && st_r.fresh
            && (st_r.s2.rdc || !st_r.busy)) begin
            start = 1'b1;
        end

        // a link read ends when select goes high, even if the host cut the frame short
        reading = (st_r.rdst != adc_port_pkg::RD_IDLE) || (serial && ext && st_r.ra2 && en);
        // after an error the interrupted word is discarded for the new one;
        // with the internal clock an unread serial word waits in the output register until its read starts
        pop = (st_r.cnt != 2'h0) && !start && (!reading || st_r.rderr)
              && !(serial && !ext && st_r.fresh);
        if (pop) begin
            st_nxt.outreg = st_r.fq[st_r.rp];
            st_nxt.rp = ~st_r.rp;
            st_nxt.fresh = serial && !ext;
        end
        case ({push, pop})
            2'b10:   st_nxt.cnt = st_r.cnt + 2'h1;
            2'b01:   st_nxt.cnt = st_r.cnt - 2'h1;
            default: st_nxt.cnt = st_r.cnt;
        endcase

        case (st_r.rdst)
            adc_port_pkg::RD_IDLE: begin
                if (start) begin
                    st_nxt.rdst = adc_port_pkg::RD_SHIFT;
                    st_nxt.fresh = 1'b0;
                    st_nxt.sdo = st_r.outreg[RES_W-1];
                    st_nxt.sh = {st_r.outreg[RES_W-2:0], 1'b0};
                    st_nxt.bcnt = '0;
                    st_nxt.ph = 2'h0;
                    st_nxt.pcnt = adc_port_pkg::PHASE_RELOAD;
                    st_nxt.mark = 1'b1;
                end
            end
            adc_port_pkg::RD_SHIFT: begin
                if (st_r.pcnt != '0) begin
                    st_nxt.pcnt = st_r.pcnt - 1'b1;
                end else begin
                    // data moves a quarter period away from either clock edge
                    st_nxt.pcnt = adc_port_pkg::PHASE_RELOAD;
                    st_nxt.ph = st_r.ph + 2'h1;
                    case (st_r.ph)
                        2'h0: st_nxt.sclk = 1'b1;
                        2'h2: st_nxt.sclk = 1'b0;
                        2'h3: begin
                            if (st_r.bcnt == adc_port_pkg::BIT_LAST) begin
                                st_nxt.rdst = adc_port_pkg::RD_IDLE;
                                st_nxt.mark = 1'b0;
                            end else begin
                                st_nxt.bcnt = st_r.bcnt + 1'b1;
                                st_nxt.sdo = st_r.sh[RES_W-1];
                                st_nxt.sh = {st_r.sh[RES_W-2:0], 1'b0};
                            end
                        end
                        default: st_nxt.ph = st_r.ph + 2'h1;
                    endcase
                end
            end
            default: st_nxt.rdst = adc_port_pkg::RD_IDLE;
        endcase

        // pin drive, registered one cycle behind the state
        st_nxt.data = '0;
        st_nxt.oe = '0;
        if (!serial) begin
            st_nxt.data = st_r.outreg;
            st_nxt.oe = {RES_W{en}};
        end else begin
            st_nxt.data[17:14] = st_r.outreg[17:14];
            st_nxt.oe[17:14] = {4{en}};
            st_nxt.data[13] = st_r.rderr;
            st_nxt.oe[13] = ext;
            st_nxt.data[12] = st_r.mark ^ st_r.s2.mk_pol;
            st_nxt.oe[12] = !ext;
            st_nxt.data[11] = st_r.sclk;
            st_nxt.oe[11] = !ext;
            st_nxt.data[10] = st_r.sdo;
            st_nxt.oe[10] = en;
        end

        if (st_r.s2.dev_rst) begin
            st_nxt = '0;
            st_nxt.s1 = st_r.s1;
            st_nxt.s2 = st_r.s2;
            st_nxt.cnv_d = 1'b1;
        end
        if (!i_rst_n) begin
            st_nxt = '0;
            st_nxt.s1 = adc_port_pkg::PINS_RST;
            st_nxt.s2 = adc_port_pkg::PINS_RST;
            st_nxt.cnv_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        st_r <= st_nxt;
    end

    assign o_data = st_r.data;
    assign o_data_oe = st_r.oe;
    assign o_busy = st_r.busy;

    // ==========================================================
    // link domain, clocked by the host's serial clock
    // invert is a static strap; changing it mid-frame glitches the clock
    assign link_clk = i_link_sclk ^ i_shift_clock_invert;

    always_comb begin
        ls_nxt = ls_r;
        ls_nxt.r1 = i_rst_n & ~i_device_reset;
        ls_nxt.r2 = ls_r.r1;
        ls_nxt.c1 = i_cs_n;
        ls_nxt.c2 = ls_r.c1;
        if (!ls_r.r2 || ls_r.c2) begin
            ls_nxt.lk = adc_port_pkg::LK_IDLE;
            ls_nxt.act = 1'b0;
            ls_nxt.bcnt = '0;
        end else begin
            case (ls_r.lk)
                adc_port_pkg::LK_IDLE: begin
                    // output word is quasi-static: core reloads it only outside a read or after a read error
                    ls_nxt.sdo = st_r.outreg[RES_W-1];
                    ls_nxt.sh = {st_r.outreg[RES_W-2:0], 1'b0};
                    ls_nxt.bcnt = '0;
                    ls_nxt.lk = adc_port_pkg::LK_SHIFT;
                    ls_nxt.act = 1'b1;
                end
                adc_port_pkg::LK_SHIFT: begin
                    if (ls_r.bcnt == adc_port_pkg::BIT_LAST) begin
                        ls_nxt.lk = adc_port_pkg::LK_DONE;
                        ls_nxt.act = 1'b0;
                    end else begin
                        ls_nxt.sdo = ls_r.sh[RES_W-1];
                        ls_nxt.sh = {ls_r.sh[RES_W-2:0], 1'b0};
                        ls_nxt.bcnt = ls_r.bcnt + 1'b1;
                    end
                end
                adc_port_pkg::LK_DONE: ls_nxt.lk = adc_port_pkg::LK_DONE;
                default: ls_nxt.lk = adc_port_pkg::LK_IDLE;
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        ls_r <= ls_nxt;
    end

    assign o_ext_serial_result_out = ls_r.sdo;

    // ==========================================================
    // assertions
    sequence s_conv_start;
        st_r.cst == adc_port_pkg::CV_IDLE && fall && !st_r.s2.dev_rst;
    endsequence
    sequence s_read_start;
        start && !st_r.s2.dev_rst;
    endsequence

    AST_BUSY_RISE: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n || st_r.s2.dev_rst)
        s_conv_start |=> o_busy [*8]) else $error("busy not held after start");
    AST_BUSY_FALL: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (push && !st_r.s2.dev_rst) |=> !o_busy && st_r.cnt != 2'h0)
        else $error("busy fell without latched result");
    AST_OE_GATE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_data_oe[17] |-> $past(!st_r.s2.cs_n && !st_r.s2.rd_n))
        else $error("output enabled without select and read");
    AST_PAR_BITS: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ($past(!serial && !st_r.s2.dev_rst) && o_data_oe[13]) |-> o_data == $past(st_r.outreg))
        else $error("parallel bits differ from result");
    AST_MSB_FIRST: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_read_start |=> st_r.sdo == $past(st_r.outreg[RES_W-1]))
        else $error("first serial bit is not the msb");
    AST_MARK_SPAN: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n || st_r.s2.dev_rst)
        s_read_start |=> st_r.mark [*8]) else $error("frame marker dropped early");
    AST_SDO_STABLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        ($changed(st_r.sdo) && $past(st_r.rdst == adc_port_pkg::RD_SHIFT))
        |-> $past(st_r.ph) == 2'h3 && !st_r.sclk) else $error("data moved near a clock edge");
    AST_EARLY_READ: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (start && st_r.busy) |-> st_r.s2.rdc) else $error("read during conversion not allowed");
    AST_SCLK_DIR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $past(serial && ext && !st_r.s2.dev_rst) |-> !o_data_oe[11] && !o_data_oe[12])
        else $error("clock pin driven with external clock");
    AST_ERR_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_r.rderr |=> !st_r.rderr ##1 st_r.cnt == 2'h0 || st_r.fresh)
        else $error("read error not a single pulse");
    AST_RESET_ABORT: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_r.s2.dev_rst |=> st_r.cst == adc_port_pkg::CV_IDLE && !o_busy)
        else $error("reset did not abort conversion");
    AST_LINK_GATE: assert property (@(posedge link_clk) disable iff (!ls_r.r2)
        ls_r.c2 |=> ls_r.lk == adc_port_pkg::LK_IDLE && !ls_r.act)
        else $error("serial clock not gated by select");

endmodule : adc_result_output_port

// file: host_link_model.sv
`timescale 1ns/1ps

module host_link_model (
    output logic      o_link_sclk,
    input  wire logic i_serial_result_out
);
    // ==========================================================
    // clock stands low between frames, as a real host would leave it
    initial o_link_sclk = 1'b0;

    // ==========================================================
    // frame of n pulses at 6 ns; the first two active edges only feed the select sync
    task automatic clock_frame(input int n, input logic inv, output adc_port_pkg::word_t got);
        int k;
        got = '0;
        for (k = 1; k <= n; k++) begin
            #3 o_link_sclk = 1'b1;
            if (inv && k >= 4 && k <= 21) begin
                got = {got[16:0], i_serial_result_out};
            end
            #3 o_link_sclk = 1'b0;
            if (!inv && k >= 3 && k <= 20) begin
                got = {got[16:0], i_serial_result_out};
            end
        end
    endtask : clock_frame
endmodule : host_link_model

// file: adc_result_output_port_tb.sv
`timescale 1ns/1ps

module adc_result_output_port_tb;
    localparam int CONV  = 8;
    localparam int LIMIT = 20000;
    logic                i_core_clk, i_rst_n, link_sclk, dev_reset, start_n, cs_n, rd_n;
    logic [1:0]          mode;
    logic                ext_sel, fmt_sel, mk_pol, sclk_inv, rdc, busy, ext_sdo, seen;
    adc_port_pkg::word_t conv_word, data, data_oe, got;
    int                  err_total, n_checks, cyc, m, k, t_rise;
    adc_port_pkg::word_t vals [0:5] = '{18'h2d1a5, 18'h00001, 18'h3fffe,
                                        18'h20000, 18'h1ffff, 18'h15a5a};

    adc_result_output_port #(.CONV_CYCLES(CONV)) dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_link_sclk(link_sclk),
        .i_device_reset(dev_reset), .i_conversion_start_n(start_n), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_mode(mode), .i_clock_source_select(ext_sel),
        .i_number_format_select(fmt_sel), .i_frame_marker_polarity(mk_pol),
        .i_shift_clock_invert(sclk_inv), .i_read_timing_or_chain_in(rdc),
        .i_conv_result(conv_word), .o_data(data), .o_data_oe(data_oe), .o_busy(busy),
        .o_ext_serial_result_out(ext_sdo));

    host_link_model host (.o_link_sclk(link_sclk), .i_serial_result_out(ext_sdo));

    // ==========================================================
    // helpers
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : tick

    task automatic chk(input string what, input adc_port_pkg::word_t exp,
                       input adc_port_pkg::word_t seen_v);
        n_checks++;
        if (seen_v !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : chk

    task automatic sel(input logic on, input int settle);
        @(posedge i_core_clk);
        cs_n <= !on;
        rd_n <= !on;
        tick(settle);
    endtask : sel

    task automatic start_conv(input adc_port_pkg::word_t v);
        int n;
        @(posedge i_core_clk);
        conv_word <= v;
        start_n   <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        start_n <= 1'b1;
        for (n = 0; n < 10 && busy !== 1'b1; n++) @(negedge i_core_clk);
        t_rise = cyc;
        chk("busy rise", 18'h1, {17'h0, busy});
    endtask : start_conv

    task automatic wait_idle;
        int n;
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge i_core_clk);
        chk("busy fall", 18'h0, {17'h0, busy});
        // busy stands at least the conversion plus the latch cycle
        chk("busy length", 18'h1, {17'h0, (cyc - t_rise) >= CONV + 1});
        tick(4);
    endtask : wait_idle

    // internal-clock read: take a bit on each rise of the pin-11 clock
    task automatic rd_int(input logic pol, output adc_port_pkg::word_t w);
        int  n, nb;
        logic prev;
        w    = '0;
        nb   = 0;
        prev = data[11];
        sel(1'b1, 0);
        for (n = 0; n < 600 && nb < 18; n++) begin
            @(negedge i_core_clk);
            if (data[11] === 1'b1 && prev === 1'b0) begin
                w = {w[16:0], data[10]};
                nb++;
                chk("marker", {17'h0, !pol}, {17'h0, data[12]});
            end
            prev = data[11];
        end
        chk("sclk oe", 18'h1, {17'h0, data_oe[11]});
        sel(1'b0, 4);
    endtask : rd_int

    task automatic rd_ext(input int n, output adc_port_pkg::word_t w);
        // edges while deselected only refill the select sync; they must start nothing
        host.clock_frame(3, sclk_inv, w);
        sel(1'b1, 4);
        chk("error flag oe", 18'h1, {17'h0, data_oe[13]});
        chk("sclk not driven", 18'h0, {17'h0, data_oe[11]});
        host.clock_frame(n, sclk_inv, w);
    endtask : rd_ext

    // ==========================================================
    // clock, watchdog
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            final_report;
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        i_rst_n = 1'b0; dev_reset = 1'b0; start_n = 1'b1; cs_n = 1'b1; rd_n = 1'b1;
        mode = 2'h0; ext_sel = 1'b0; fmt_sel = 1'b0; mk_pol = 1'b0; sclk_inv = 1'b0;
        rdc = 1'b0; conv_word = '0; err_total = 0; n_checks = 0; cyc = 0;
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        tick(4);
        host.clock_frame(4, 1'b0, got);
        chk("idle oe", 18'h0, data_oe);
        for (m = 0; m < 3; m++) begin
            @(posedge i_core_clk);
            mode    <= m[1:0];
            fmt_sel <= m[0];
            start_conv(vals[m]);
            wait_idle;
            sel(1'b1, 4);
            chk("parallel oe", 18'h3ffff, data_oe);
            chk("parallel data", vals[m] ^ {m[0], 17'h0}, data);
            sel(1'b0, 4);
            chk("float oe", 18'h0, data_oe);
        end
        // serial, internal clock: fill the buffer while a read holds the output word
        @(posedge i_core_clk);
        mode    <= adc_port_pkg::MODE_SERIAL;
        fmt_sel <= 1'b0;
        rdc     <= 1'b1;
        start_conv(vals[0]);
        wait_idle;
        fork
            rd_int(1'b0, got);
            begin
                tick(20);
                for (m = 1; m < 4; m++) begin
                    start_conv(vals[m]);
                    if (m < 3) begin
                        wait_idle;
                    end
                end
                tick(40);
                chk("busy held by full buffer", 18'h1, {17'h0, busy});
            end
        join
        chk("serial word", vals[0], got);
        wait_idle;
        for (m = 1; m < 4; m++) begin
            @(posedge i_core_clk);
            mk_pol <= m[0];
            rd_int(m[0], got);
            chk("drained word", vals[m], got);
        end
        @(posedge i_core_clk);
        rdc <= 1'b0;
        start_conv(vals[4]);
        rd_int(1'b1, got);
        chk("read after conversion", vals[4], got);
        // serial, external clock, both edge choices
        @(posedge i_core_clk);
        ext_sel <= 1'b1;
        for (m = 0; m < 2; m++) begin
            @(posedge i_core_clk);
            sclk_inv <= m[0];
            start_conv(vals[m + 4]);
            wait_idle;
            rd_ext(21, got);
            chk("ext word", vals[m + 4], got);
            sel(1'b0, 4);
        end
        // unfinished read when the next result lands
        start_conv(vals[1]);
        wait_idle;
        rd_ext(5, got);
        start_conv(vals[2]);
        seen = 1'b0;
        for (k = 0; k < 60; k++) begin
            @(negedge i_core_clk);
            if (data[13] === 1'b1) begin
                seen = 1'b1;
            end
        end
        chk("read error pulse", 18'h1, {17'h0, seen});
        sel(1'b0, 4);
        // device reset in mid-conversion
        start_conv(vals[3]);
        @(posedge i_core_clk);
        dev_reset <= 1'b1;
        tick(5);
        chk("busy after reset", 18'h0, {17'h0, busy});
        @(posedge i_core_clk);
        dev_reset <= 1'b0;
        tick(6);
        final_report;
    end
endmodule : adc_result_output_port_tb
